// File: srm_cfg.svh
// Offsets, field positions, opcodes and timing counts of the serial ROM
// master. Included by the top module only.
`ifndef SRM_CFG_SVH
`define SRM_CFG_SVH

// Configuration-space register offsets
`define SRM_OFF_CTRL 8'h90
`define SRM_OFF_DATA 8'h94

// Control register fields
`define SRM_CTL_OP_LSB 0
`define SRM_CTL_ADDR_EN 8
`define SRM_CTL_CNT_LSB 9
`define SRM_CTL_GO 12
`define SRM_CTL_LED_ALL 13
`define SRM_CTL_BUSY 16
`define SRM_CTL_PRESENT 17
`define SRM_CTL_DIRECT 18

// Serial memory opcodes
`define SRM_OP_STATUS_WRITE 8'h01
`define SRM_OP_PROGRAM 8'h02
`define SRM_OP_READ 8'h03
`define SRM_OP_LATCH_CLEAR 8'h04
`define SRM_OP_STATUS_READ 8'h05
`define SRM_OP_LATCH_SET 8'h06
`define SRM_OP_IDENTITY 8'h15
`define SRM_OP_SECTOR_ERASE 8'h52
`define SRM_OP_CHIP_ERASE 8'h62

// Serial clock dividers of the bus clock
`define SRM_DIV_SLOW 4
`define SRM_DIV_FAST 8

// Reset values
`define SRM_CTRL_RST 32'h0000_0000
`define SRM_DATA_RST 32'h0000_0000

// Status byte that an absent memory returns through the pull-up
`define SRM_ABSENT_BYTE 8'hFF

`endif

// File: srm_pkg.sv
// Types shared by the serial ROM master, its checker and its bench.
// Assumes srm_cfg.svh is on the include path.
package srm_pkg;
	// Host request: config space or ROM window access
	typedef struct packed {
		logic rom;
		logic wr;
		logic [16:0] addr;
		logic [3:0] be_n;
		logic [31:0] wdata;
	} srm_req_s;

	// Answer word returned to the host
	typedef struct packed {
		logic [31:0] rdata;
	} srm_ans_s;

	typedef enum logic [2:0] {
		ST_BOOT, ST_IDLE, ST_SETUP, ST_SHIFT, ST_GAP, ST_DONE
	} srm_state_e;
endpackage

// File: srm_pair_buf.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
module srm_pair_buf #(
	parameter int WIDTH = 32
) (
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	// Refuse a buffer with no data bits
	if (WIDTH < 1) begin : g_width_check
		$error("srm_pair_buf: WIDTH must be positive");
	end

	logic [WIDTH-1:0] slot0, slot1, next_slot0, next_slot1;
	logic [1:0] count, next_count;
	logic out_valid, next_out_valid;
	logic push, pop;

	// Slot0 is the head; slot1 only fills while the drain stalls
	always_comb begin
		push = in_valid_i && (count != 2'd2);
		pop = out_ready_i && (count != 2'd0);
		next_slot0 = slot0;
		next_slot1 = slot1;
		next_count = count;
		if (pop) begin
			next_slot0 = slot1;
		end
		if (push) begin
			if (next_count - {1'b0, pop} == 2'd0) begin
				next_slot0 = in_data_i;
			end else begin
				next_slot1 = in_data_i;
			end
		end
		next_count = count + {1'b0, push} - {1'b0, pop};
		// Valid is registered so the host sees it straight from a flop
		next_out_valid = (next_count != 2'd0);
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			slot0 <= '0;
			slot1 <= '0;
			count <= 2'd0;
			out_valid <= 1'b0;
		end else begin
			slot0 <= next_slot0;
			slot1 <= next_slot1;
			count <= next_count;
			out_valid <= next_out_valid;
		end
	end

	assign in_ready_o = (count != 2'd2);
	assign out_valid_o = out_valid;
	assign out_data_o = slot0;
endmodule

// File: srm_top.sv
// Serial ROM master with activity LED pin sharing.
// Assumes host requests and port activity are synchronous to clk_sys_i.
`timescale 1ns/100ps
`include "srm_cfg.svh"

// Notes on behaviour
// - One serial memory up to 128 KB on a four-wire link.
// - After reset a status read probes the memory and records presence.
// - Master only: drives select, clock, data out; samples data in.
// - Serial clock is bus clock divided by 4, or 8 for fast buses.
// - Clock idles low; data launched before rising edge, sampled on it.
// - Each data-out bit stays stable across the rising edge.
// - Active-low select, pulled up, deselected when idle.
// - Commands go through config offsets 90h/94h or the ROM window.
// - Status write 01h and status read 05h come from config space.
// - Latch set 06h and latch clear 04h come from config space.
// - A ROM window write sends program opcode 02h.
// - A ROM window read sends read opcode 03h.
// - Sector erase 52h and chip erase 62h come from config space.
// - Identity read 15h comes from config space.
// - Emulation mode: first LED low when port 1 or 2 is active.
// - Emulation mode: second LED low when port 3 or 4 is active.
// - Direct mode: ports 1-4 on first LED, second LED, clock, data out.
// - During a transfer the shared pins carry the serial link.
// - A control bit merges all four ports onto the first LED.
// - ROM read address takes bus bits 16:2, bits 23:17 zero.
// - Byte enables pick length 1, 2 or 4 and the low address bits.
// - A request during a busy memory cycle waits until the engine is idle.
module srm_top
	import srm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic bus_fast_i,
	input wire logic port_mode_select_i,
	input wire logic [3:0] port_activity_i,
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire srm_req_s req_i,
	output logic ans_valid_o,
	input wire logic ans_ready_i,
	output srm_ans_s ans_o,
	output logic rom_select_n_o,
	output logic rom_clock_o,
	output logic rom_serial_out_o,
	input wire logic rom_serial_in_i,
	output logic activity_led_first_o,
	output logic activity_led_second_o
);
	srm_state_e state, next_state;
	logic [31:0] ctrl, next_ctrl, data, next_data;
	logic [63:0] tx, next_tx;
	logic [31:0] rx, next_rx;
	logic [6:0] bits_left, next_bits_left;
	logic [2:0] tick_cnt, next_tick_cnt;
	logic sclk, next_sclk, sel_n, next_sel_n;
	logic present, next_present, direct, next_direct;
	logic mode_taken, next_mode_taken;
	logic rom_op, next_rom_op, boot_op, next_boot_op;
	logic [1:0] rom_off, next_rom_off;
	logic [2:0] rom_len, next_rom_len;
	logic ready, next_ready;
	logic push_valid, buf_ready;
	srm_ans_s push_ans;
	logic half_tick;
	logic [2:0] half_period;
	logic activity_led_second, led2, next_activity_led_second, next_led2;
	logic pin_clk, pin_dout, next_pin_clk, next_pin_dout;

	// Byte reversal of a word
	function automatic logic [31:0] bswap(input logic [31:0] w);
		bswap = {w[7:0], w[15:8], w[23:16], w[31:24]};
	endfunction

	// Length and low address bits from active-low byte enables
	function automatic logic [4:0] be_decode(input logic [3:0] be_n);
		case (be_n)
			4'hE: be_decode = {3'd1, 2'd0};
			4'hD: be_decode = {3'd1, 2'd1};
			4'hB: be_decode = {3'd1, 2'd2};
			4'h7: be_decode = {3'd1, 2'd3};
			4'hC: be_decode = {3'd2, 2'd0};
			4'h3: be_decode = {3'd2, 2'd2};
			default: be_decode = {3'd4, 2'd0};
		endcase
	endfunction

	// Half serial period from the bus speed
	always_comb begin
		half_period = bus_fast_i ? 3'(`SRM_DIV_FAST / 2) :
			3'(`SRM_DIV_SLOW / 2);
		half_tick = (tick_cnt == half_period - 3'd1);
	end

	// Command engine, register file and request handling
	always_comb begin
		logic [2:0] cnt;
		logic [4:0] dec;
		logic [31:0] dbytes;
		logic [31:0] rdv;
		cnt = 3'd0;
		dec = 5'd0;
		dbytes = 32'h0;
		rdv = 32'h0;
		next_state = state;
		next_ctrl = ctrl;
		next_data = data;
		next_tx = tx;
		next_rx = rx;
		next_bits_left = bits_left;
		next_tick_cnt = tick_cnt;
		next_sclk = sclk;
		next_sel_n = sel_n;
		next_present = present;
		next_direct = direct;
		next_mode_taken = 1'b1;
		next_rom_op = rom_op;
		next_boot_op = boot_op;
		next_rom_off = rom_off;
		next_rom_len = rom_len;
		next_ready = 1'b0;
		push_valid = 1'b0;
		push_ans.rdata = 32'h0;
		// Mode strap is caught on the first cycle after reset release
		if (!mode_taken) begin
			next_direct = !port_mode_select_i;
		end
		case (state)
			ST_BOOT: begin
				// Presence probe with one status read
				next_tx = {`SRM_OP_STATUS_READ, 56'h0};
				next_bits_left = 7'd16;
				next_boot_op = 1'b1;
				next_rom_op = 1'b0;
				next_state = ST_SETUP;
			end
			ST_IDLE: begin
				next_ready = buf_ready;
				if (req_valid_i && ready) begin
					next_ready = 1'b0;
					if (req_i.rom) begin
						dec = be_decode(req_i.be_n);
						next_rom_len = dec[4:2];
						next_rom_off = dec[1:0];
						next_rom_op = 1'b1;
						next_boot_op = 1'b0;
						next_bits_left = 7'(32 + 8 * dec[4:2]);
						if (req_i.wr) begin
							dbytes = bswap(req_i.wdata >> (8 * dec[1:0]));
							next_tx = {`SRM_OP_PROGRAM, 7'h00,
								req_i.addr[16:2], dec[1:0], dbytes};
						end else begin
							next_tx = {`SRM_OP_READ, 7'h00,
								req_i.addr[16:2], dec[1:0], 32'h0};
						end
						next_state = ST_SETUP;
					end else if (req_i.wr) begin
						if (req_i.addr[7:0] == `SRM_OFF_CTRL) begin
							next_ctrl[13:0] = req_i.wdata[13:0];
							next_ctrl[`SRM_CTL_GO] = 1'b0;
						end else if (req_i.addr[7:0] == `SRM_OFF_DATA) begin
							next_data = req_i.wdata;
						end
						// Config write answers at once with an all-zero word
						push_valid = 1'b1;
						if (req_i.addr[7:0] == `SRM_OFF_CTRL &&
							req_i.wdata[`SRM_CTL_GO]) begin
							cnt = req_i.wdata[11:9] > 3'd4 ? 3'd4 :
								req_i.wdata[11:9];
							dbytes = data << (8 * (3'd4 - cnt));
							if (req_i.wdata[`SRM_CTL_ADDR_EN]) begin
								next_tx = {req_i.wdata[7:0], data[23:0],
									dbytes};
								next_bits_left = 7'(32 + 8 * cnt);
							end else begin
								next_tx = {req_i.wdata[7:0], dbytes, 24'h0};
								next_bits_left = 7'(8 + 8 * cnt);
							end
							next_rom_op = 1'b0;
							next_boot_op = 1'b0;
							next_ctrl[`SRM_CTL_BUSY] = 1'b1;
							next_state = ST_SETUP;
						end
					end else begin
						push_valid = 1'b1;
						if (req_i.addr[7:0] == `SRM_OFF_CTRL) begin
							push_ans.rdata = ctrl;
						end else if (req_i.addr[7:0] == `SRM_OFF_DATA) begin
							push_ans.rdata = data;
						end
					end
				end
			end
			ST_SETUP: begin
				// Select low and first bit on the pin half a period early
				next_sel_n = 1'b0;
				next_sclk = 1'b0;
				next_tick_cnt = tick_cnt + 3'd1;
				if (half_tick) begin
					next_tick_cnt = 3'd0;
					next_state = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				next_tick_cnt = tick_cnt + 3'd1;
				if (half_tick) begin
					next_tick_cnt = 3'd0;
					if (!sclk) begin
						// Rising edge: memory latches, master samples
						next_sclk = 1'b1;
						next_rx = {rx[30:0], rom_serial_in_i};
					end else begin
						// Falling edge: launch next bit MSB first
						next_sclk = 1'b0;
						next_tx = {tx[62:0], 1'b0};
						next_bits_left = bits_left - 7'd1;
						if (bits_left == 7'd1) begin
							next_state = ST_GAP;
						end
					end
				end
			end
			ST_GAP: begin
				// Release select and hold it high one half period
				next_sel_n = 1'b1;
				next_tick_cnt = tick_cnt + 3'd1;
				if (half_tick) begin
					next_tick_cnt = 3'd0;
					next_state = ST_DONE;
				end
			end
			ST_DONE: begin
				if (boot_op) begin
					next_present = (rx[7:0] != `SRM_ABSENT_BYTE);
					next_state = ST_IDLE;
				end else if (rom_op) begin
					// Bytes return in their lanes; the other lanes read as zeros
					rdv = bswap(rx) >> (8 * (3'd4 - rom_len));
					push_ans.rdata = rdv << (8 * rom_off);
					push_valid = 1'b1;
					if (buf_ready) begin
						next_state = ST_IDLE;
					end
				end else begin
					next_data = rx;
					next_ctrl[`SRM_CTL_BUSY] = 1'b0;
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
				next_sel_n = 1'b1;
				next_sclk = 1'b0;
			end
		endcase
		next_ctrl[`SRM_CTL_PRESENT] = next_present;
		next_ctrl[`SRM_CTL_DIRECT] = next_direct;
	end

	// LED and shared pin drive, all from flip-flops
	always_comb begin
		logic xfer;
		xfer = (state == ST_SETUP) || (state == ST_SHIFT) ||
			(state == ST_GAP);
		next_activity_led_second = !(port_activity_i[0] || port_activity_i[1]);
		next_led2 = !(port_activity_i[2] || port_activity_i[3]);
		if (direct) begin
			next_activity_led_second = !port_activity_i[0];
			next_led2 = !port_activity_i[1];
		end
		if (ctrl[`SRM_CTL_LED_ALL]) begin
			next_activity_led_second = !(|port_activity_i);
		end
		next_pin_clk = next_sclk;
		next_pin_dout = next_tx[63];
		if (direct && !xfer && next_sel_n) begin
			next_pin_clk = !port_activity_i[2];
			next_pin_dout = !port_activity_i[3];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!nrst_i) begin
			state <= ST_BOOT;
			ctrl <= `SRM_CTRL_RST;
			data <= `SRM_DATA_RST;
			tx <= 64'h0;
			rx <= 32'h0;
			bits_left <= 7'd0;
			tick_cnt <= 3'd0;
			sclk <= 1'b0;
			sel_n <= 1'b1;
			present <= 1'b0;
			direct <= 1'b0;
			mode_taken <= 1'b0;
			rom_op <= 1'b0;
			boot_op <= 1'b0;
			rom_off <= 2'd0;
			rom_len <= 3'd0;
			ready <= 1'b0;
			activity_led_second <= 1'b1;
			led2 <= 1'b1;
			pin_clk <= 1'b0;
			pin_dout <= 1'b0;
		end else begin
			state <= next_state;
			ctrl <= next_ctrl;
			data <= next_data;
			tx <= next_tx;
			rx <= next_rx;
			bits_left <= next_bits_left;
			tick_cnt <= next_tick_cnt;
			sclk <= next_sclk;
			sel_n <= next_sel_n;
			present <= next_present;
			direct <= next_direct;
			mode_taken <= next_mode_taken;
			rom_op <= next_rom_op;
			boot_op <= next_boot_op;
			rom_off <= next_rom_off;
			rom_len <= next_rom_len;
			ready <= next_ready;
			activity_led_second <= next_activity_led_second;
			led2 <= next_led2;
			pin_clk <= next_pin_clk;
			pin_dout <= next_pin_dout;
		end
	end

	// Answer buffer: with two answers unread, a stalled host holds a ROM read in ST_DONE and keeps new requests out in ST_IDLE
	srm_pair_buf #(
		.WIDTH($bits(srm_ans_s))
	) u_ans_buf (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.in_valid_i(push_valid),
		.in_ready_o(buf_ready),
		.in_data_i(push_ans),
		.out_valid_o(ans_valid_o),
		.out_ready_i(ans_ready_i),
		.out_data_o(ans_o)
	);

	assign req_ready_o = ready;
	assign rom_select_n_o = sel_n;
	assign rom_clock_o = pin_clk;
	assign rom_serial_out_o = pin_dout;
	assign activity_led_first_o = activity_led_second;
	assign activity_led_second_o = led2;
endmodule

// File: srm_mem_model.sv
// Behavioural serial memory at the far end of the ROM master link.
// Assumes mode 0 framing and one command per select.
`timescale 1ns/100ps
module srm_mem_model #(
	parameter logic [7:0] STATUS = 8'h02,
	parameter logic [7:0] ID_BASE = 8'h5A // Arbitrary identity value
) (
	input wire logic sel_n_i,
	input wire logic clk_i,
	input wire logic si_i,
	output logic so_o,
	output logic [7:0] op_o,
	output logic [23:0] addr_o,
	output logic [31:0] rx_o
);
	int n = 0;
	int j;
	logic [7:0] b;
	// Array commands carry 24 address bits after the opcode
	function automatic int hdr(logic [7:0] op);
		return (op == 8'h02 || op == 8'h03 || op == 8'h52) ? 32 : 8;
	endfunction
	initial begin
		so_o = 1'h1;
		op_o = 8'h00;
	end
	// Bit counter restarts at each select
	always @(negedge sel_n_i) n = 0;
	// Incoming bits latched on the rising edge
	always @(posedge clk_i) if (!sel_n_i) begin
		if (n < 8) op_o = {op_o[6:0], si_i};
		else if (n < hdr(op_o)) addr_o = {addr_o[22:0], si_i};
		else rx_o = {rx_o[30:0], si_i};
		n++;
	end
	// Answer launched on the falling edge; released line floats high
	always @(negedge clk_i or posedge sel_n_i) begin
		j = n - hdr(op_o);
		case (op_o)
			8'h05: b = STATUS;
			8'h15: b = ID_BASE + 8'(j / 8);
			8'h03: b = addr_o[7:0] + 8'(j / 8);
			default: b = 8'hFF;
		endcase
		so_o = (sel_n_i || j < 0) ? 1'h1 : b[7 - j % 8];
	end
endmodule

// File: srm_top_chk.sv
// Assertions on the pins of the serial ROM master.
// Assumes the mode strap changes only in reset, the divider only when idle.
`timescale 1ns/100ps
module srm_top_chk
	import srm_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic nrst_i,
	input wire logic bus_fast_i,
	input wire logic port_mode_select_i,
	input wire logic [3:0] port_activity_i,
	input wire logic ans_valid_o,
	input wire logic ans_ready_i,
	input wire srm_ans_s ans_o,
	input wire logic rom_select_n_o,
	input wire logic rom_clock_o,
	input wire logic rom_serial_out_o,
	input wire logic activity_led_first_o,
	input wire logic activity_led_second_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	// Link framing and clock shape
	a_reset_idle: assert property ($rose(nrst_i) |-> rom_select_n_o
		&& !rom_clock_o) else $error("link busy after reset");
	a_sel_lead: assert property ($fell(rom_select_n_o) |->
		!rom_clock_o [*2]) else $error("no lead before first clock");
	a_slow_high: assert property (!bus_fast_i && !rom_select_n_o &&
		$rose(rom_clock_o) |-> rom_clock_o [*2] ##1 !rom_clock_o)
		else $error("slow clock high width");
	a_fast_high: assert property (bus_fast_i && !rom_select_n_o &&
		$rose(rom_clock_o) |-> rom_clock_o [*4] ##1 !rom_clock_o)
		else $error("fast clock high width");
	a_sdo_hold: assert property (!rom_select_n_o && $rose(rom_clock_o)
		|-> $stable(rom_serial_out_o) ##1 $stable(rom_serial_out_o))
		else $error("data out moved at rising clock");
	a_emul_idle: assert property (port_mode_select_i && rom_select_n_o
		|-> !rom_clock_o) else $error("clock not low while idle");
	// Activity lights and answer hold
	a_led_pair12: assert property (port_mode_select_i &&
		|port_activity_i[1:0] |-> ##[1:2] !activity_led_first_o)
		else $error("first light off with port 1 or 2 busy");
	a_led_pair34: assert property (port_mode_select_i &&
		|port_activity_i[3:2] |-> ##[1:2] !activity_led_second_o)
		else $error("second light off with port 3 or 4 busy");
	a_led_quiet: assert property ((port_mode_select_i &&
		port_activity_i[3:2] == 2'h0) [*3] |-> activity_led_second_o)
		else $error("second light on while ports 3 and 4 quiet");
	a_led_direct: assert property (!port_mode_select_i &&
		port_activity_i[1] |-> ##[1:2] !activity_led_second_o)
		else $error("port 2 light off in direct mode");
	a_ans_hold: assert property (ans_valid_o && !ans_ready_i |=>
		ans_valid_o && $stable(ans_o)) else $error("answer dropped");
	c_fast_frame: cover property (bus_fast_i && $fell(rom_select_n_o));
	c_slow_frame: cover property (!bus_fast_i && $fell(rom_select_n_o));
	c_ans_stall: cover property (ans_valid_o && !ans_ready_i);
endmodule

bind srm_top srm_top_chk srm_top_chk_inst (.clk_sys_i(clk_sys_i),
	.nrst_i(nrst_i), .bus_fast_i(bus_fast_i), .ans_o(ans_o),
	.port_mode_select_i(port_mode_select_i), .ans_valid_o(ans_valid_o),
	.port_activity_i(port_activity_i), .ans_ready_i(ans_ready_i),
	.rom_select_n_o(rom_select_n_o), .rom_clock_o(rom_clock_o),
	.rom_serial_out_o(rom_serial_out_o),
	.activity_led_first_o(activity_led_first_o),
	.activity_led_second_o(activity_led_second_o));

// File: testbench.sv
// Self-checking bench for the serial ROM master.
// Assumes the memory model and checker are compiled before it.
`timescale 1ns/100ps
module testbench
	import srm_pkg::*;
;
	logic clk_sys_i, nrst_i, bus_fast, mode_sel, req_valid, req_ready;
	logic ans_valid, ans_ready, sel_n, sclk, rom_serial_out, rom_serial_in, activity_led_second, led2, hold;
	logic [3:0] act;
	logic [16:0] a;
	logic [31:0] rd, wd, m_rx;
	logic [7:0] m_op;
	logic [23:0] m_addr;
	srm_req_s req;
	srm_ans_s ans;
	int num_errors = 0, checked = 0, cycles = 0;
	integer seed = 32'h41CA4D8E;
	logic [7:0] ops [7] = '{8'h05, 8'h15, 8'h06, 8'h04, 8'h01, 8'h52, 8'h62};
	logic [3:0] bes [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hC, 4'h3, 4'h0};

	srm_top srm_top_inst (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.bus_fast_i(bus_fast), .port_mode_select_i(mode_sel),
		.port_activity_i(act), .req_valid_i(req_valid),
		.req_ready_o(req_ready), .req_i(req), .ans_valid_o(ans_valid),
		.ans_ready_i(ans_ready), .ans_o(ans), .rom_select_n_o(sel_n),
		.rom_clock_o(sclk), .rom_serial_out_o(rom_serial_out), .rom_serial_in_i(rom_serial_in),
		.activity_led_first_o(activity_led_second), .activity_led_second_o(led2));
	srm_mem_model srm_mem_model_inst (.sel_n_i(sel_n), .clk_i(sclk),
		.si_i(rom_serial_out), .so_o(rom_serial_in), .op_o(m_op), .addr_o(m_addr), .rx_o(m_rx));

	initial begin
		clk_sys_i = 1'h0;
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// Random port activity and host stalls between edges
	always @(negedge clk_sys_i) begin
		ans_ready <= ($random(seed) & 3) != 0;
		if (!hold) act <= 4'($random(seed));
	end
	// Hang guard
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			end_sim;
		end
	end

	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// One host request held until taken, then its answer
	task automatic xfer(logic rom, logic wr, logic [16:0] ad,
		logic [3:0] be, logic [31:0] d, output logic [31:0] r);
		int i;
		@(negedge clk_sys_i);
		req = '{rom, wr, ad, be, d};
		req_valid = 1'h1;
		i = 0;
		do begin @(posedge clk_sys_i); i++; end while (!req_ready && i < 3000);
		// A request never taken counts as a mismatch
		if (!req_ready) num_errors++;
		@(negedge clk_sys_i);
		req_valid = 1'h0;
		i = 0;
		do begin @(posedge clk_sys_i); i++; end
			while (!(ans_valid && ans_ready) && i < 3000);
		// An answer that never comes counts as a mismatch
		if (!(ans_valid && ans_ready)) num_errors++;
		r = ans.rdata;
	endtask
	task automatic cfg(logic wr, logic [7:0] off, logic [31:0] d);
		xfer(1'h0, wr, {9'h000, off}, 4'h0, d, rd);
	endtask
	function automatic logic [1:0] be_off(logic [3:0] be);
		case (be)
			4'hD: return 2'h1;
			4'hB, 4'h3: return 2'h2;
			4'h7: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction
	function automatic int be_len(logic [3:0] be);
		case (be)
			4'hE, 4'hD, 4'hB, 4'h7: return 1;
			4'hC, 4'h3: return 2;
			default: return 4;
		endcase
	endfunction
	// ROM window read; model answers address plus byte index
	task automatic rom_rd(logic [16:0] ad, logic [3:0] be);
		logic [1:0] o;
		logic [31:0] e, m;
		o = be_off(be);
		e = 32'h0;
		m = 32'h0;
		xfer(1'h1, 1'h0, ad, be, 32'h0, rd);
		for (int i = 0; i < be_len(be); i++) begin
			e[8*(o+i) +: 8] = {ad[7:2], o} + 8'(i);
			m[8*(o+i) +: 8] = 8'hFF;
		end
		chk("rom_rd", rd & m, e);
		chk("rom_op", m_op, 8'h03);
		chk("rom_addr", m_addr, {7'h00, ad[16:2], o});
	endtask

	initial begin
		nrst_i = 1'h0;
		bus_fast = 1'h0;
		mode_sel = 1'h1;
		act = 4'h0;
		req_valid = 1'h0;
		req = '0;
		ans_ready = 1'h0;
		hold = 1'h0;
		repeat (20) @(negedge clk_sys_i);
		nrst_i = 1'h1;
		cfg(1'h0, 8'h90, 32'h0);
		chk("ctrl_rst", rd, 32'h0002_0000);
		cfg(1'h1, 8'h40, 32'hFFFF_FFFF);
		cfg(1'h0, 8'h40, 32'h0);
		chk("unmapped", rd, 32'h0);
		// Every config-space command, four bytes each
		foreach (ops[k]) begin
			cfg(1'h1, 8'h94, 32'h0012_3456);
			cfg(1'h1, 8'h90, {19'h0, 1'h1, 3'h4, ops[k] == 8'h52, ops[k]});
			cfg(1'h0, 8'h90, 32'h0);
			chk("op", m_op, ops[k]);
			chk("busy", rd[16], 32'h0);
			cfg(1'h0, 8'h94, 32'h0);
			if (ops[k] == 8'h05) chk("stat", rd, 32'h0202_0202);
			if (ops[k] == 8'h15) chk("ident", rd, 32'h5A5B_5C5D);
			if (ops[k] == 8'h52) chk("sect", m_addr, 32'h12_3456);
		end
		// Short count: one status byte lands in the low lane
		cfg(1'h1, 8'h90, {19'h0, 1'h1, 3'h1, 1'h0, 8'h05});
		cfg(1'h0, 8'h94, 32'h0);
		chk("stat1", rd[7:0], 32'h02);
		// Count above four acts as four
		cfg(1'h1, 8'h90, {19'h0, 1'h1, 3'h7, 1'h0, 8'h15});
		cfg(1'h0, 8'h94, 32'h0);
		chk("ident7", rd, 32'h5A5B_5C5D);
		// ROM reads over all byte enables at both dividers
		repeat (3) foreach (bes[k]) begin
			@(negedge clk_sys_i);
			bus_fast = 1'($random(seed));
			a = 17'($random(seed));
			rom_rd({a[16:2], 2'h0}, bes[k]);
		end
		wd = $random(seed);
		xfer(1'h1, 1'h1, {a[16:2], 2'h0}, 4'h0, wd, rd);
		chk("prog_op", m_op, 8'h02);
		chk("prog_data", m_rx, {wd[7:0], wd[15:8], wd[23:16], wd[31:24]});
		// Direct mode after a second reset
		@(negedge clk_sys_i);
		hold = 1'h1;
		nrst_i = 1'h0;
		mode_sel = 1'h0;
		@(negedge clk_sys_i);
		act = 4'h4;
		repeat (20) @(negedge clk_sys_i);
		nrst_i = 1'h1;
		cfg(1'h0, 8'h90, 32'h0);
		chk("direct", rd[18:17], 32'h3);
		@(negedge clk_sys_i);
		chk("led_p3", {sclk, rom_serial_out}, 32'h1);
		cfg(1'h1, 8'h90, 32'h0000_2000);
		@(negedge clk_sys_i);
		act = 4'h8;
		repeat (3) @(negedge clk_sys_i);
		chk("led_all", activity_led_second, 32'h0);
		chk("led_p4", {sclk, rom_serial_out}, 32'h2);
		hold = 1'h0;
		rom_rd(17'h1_2340, 4'h0);
		end_sim;
	end
endmodule
